// ===== verilog/sbc_restart_failsafe_modes.sv
// restart, fail-safe and development mode sequencer of a system basis chip
`timescale 1ns/1ps
`default_nettype none
`include "sbc_seq_defs.svh"

// Contract
// - restart mode resets microcontroller, reset low
// - restart ends alone into normal, reset released
// - restart delay picked by reset-delay bit
// - restart cause kept until reason read
// - sleep wake reports source, no interrupt
// - restart never turns active limp-home off
// - first response after normal carries restart reason
// - external reset low: restart, reason bits
// - clamped reset: cfg1/3 restart, cfg2/4 fail-safe
// - watchdog failure handled per configuration
// - config 2 watchdog failure goes straight fail-safe; in flash mode the code restarts instead
// - flash command or watchdog fault restarts
// - undervoltage reset restarts, regulator ramps up
// - fail-safe: regulators off, wake-capable, limp-home
// - fail-safe on wd, uv timeout, thermal
// - thermal fail-safe latched until cooled
// - fail-safe wake restarts, clears counter, limp-home
// - first response carries fail-safe reason
// - test pin low at power-up: config 0
// - config 0 watchdog failure causes no restart; in flash mode the code still restarts on it
// - config 0 watchdog failure flags interrupt, status; in flash mode the code restarts instead and sets neither
// - factory flash: logic unpowered, nothing active
// - init needs mode command within 256 ms
module sbc_restart_failsafe_modes
  import sbc_seq_pkg::*;
#(
  parameter int                     TW              = `TIMER_W,
  parameter logic [`TIMER_W-1:0]    INIT_TIMEOUT    = `TIMER_W'(`INIT_TIMEOUT_CYC),
  parameter logic [`TIMER_W-1:0]    RST_DELAY_SHORT = `TIMER_W'(`RST_DELAY_SHORT_CYC),
  parameter logic [`TIMER_W-1:0]    RST_DELAY_LONG  = `TIMER_W'(`RST_DELAY_LONG_CYC)
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 test_pin_low_i,
  input  wire logic [1:0]           config_pins_i,
  input  wire logic                 reset_delay_sel_i,
  input  wire logic                 cmd_normal_i,
  input  wire logic                 cmd_flash_i,
  input  wire logic                 cmd_sleep_i,
  input  wire logic                 cmd_stop_i,
  input  wire logic                 cmd_restart_i,
  input  wire logic                 cmd_lh_on_i,
  input  wire logic                 cmd_lh_off_i,
  input  wire logic                 wd_fail_i,
  input  wire logic                 wd_ok_i,
  input  wire logic                 reset_ext_low_i,
  input  wire logic                 reset_clamped_i,
  input  wire logic                 uv_reset_i,
  input  wire logic                 uv_timeout_i,
  input  wire logic                 vs_above_lh_thr_i,
  input  wire logic                 thermal_shutdown_i,
  input  wire logic                 wake_i,
  input  wire logic [`WAKE_W-1:0]   wake_src_i,
  input  wire logic                 spi_response_i,
  input  wire logic                 read_lh_reason_i,
  input  wire logic                 read_rm_reason_i,
  input  wire logic                 read_wake_i,
  input  wire logic                 read_reset_status_i,
  output logic                      mcu_reset_out_n_o,
  output logic                      limp_home_output_o,
  output logic                      main_regulator_en_o,
  output logic                      aux_regulators_allow_o,
  output logic                      trx_wake_capable_o,
  output logic [2:0]                limp_home_reason_bits_o,
  output logic [1:0]                restart_reason_bits_o,
  output logic [`WAKE_W-1:0]        wake_source_bits_o,
  output logic                      reason_report_pending_o,
  output logic                      wd_fail_int_o,
  output logic                      reset_status_bit_o,
  output logic [2:0]                mode_o,
  output logic [2:0]                config_o
);
  delay_timer_if #(.W(TW)) tif ();

  delay_timer #(.W(TW)) u_timer (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tif     (tif)
  );

  sbc_mode_t                state;
  sbc_mode_t                next_state;
  config_sel_t              cfg;
  config_sel_t              next_cfg;
  logic                     strapped;
  logic                     next_strapped;
  logic                     lh;
  logic                     next_lh;
  logic [2:0]               lh_reason;
  logic [2:0]               next_lh_reason;
  logic [1:0]               rm_reason;
  logic [1:0]               next_rm_reason;
  logic [`WAKE_W-1:0]       wk_bits;
  logic [`WAKE_W-1:0]       next_wk_bits;
  logic [`WD_CNT_W-1:0]     wd_cnt;
  logic [`WD_CNT_W-1:0]     next_wd_cnt;
  logic                     tsd_latched;
  logic                     next_tsd_latched;
  logic                     report;
  logic                     next_report;
  logic                     wd_int;
  logic                     next_wd_int;
  logic                     rst_status;
  logic                     next_rst_status;
  logic                     rst_out_n;
  logic                     next_rst_out_n;
  logic                     main_en;
  logic                     next_main_en;
  logic                     aux_allow;
  logic                     next_aux_allow;
  logic                     trx_wk;
  logic                     next_trx_wk;
  logic [TW-1:0]            load_value;

  function automatic logic [TW-1:0] restart_delay(input logic sel);
    return sel ? RST_DELAY_LONG : RST_DELAY_SHORT;
  endfunction

  // delay reloads on every entry into a timed state, and at power-up
  assign tif.load  = (next_state != state) || !strapped;
  assign tif.value = load_value;

  always_comb begin
    unique case (next_state)
      ST_INIT:    load_value = INIT_TIMEOUT;
      ST_RESTART: load_value = restart_delay(reset_delay_sel_i);
      default:    load_value = RST_DELAY_LONG;
    endcase
  end

  always_comb begin
    logic active;
    logic second_fail;
    active           = 1'b0;
    second_fail      = (wd_cnt != '0);
    next_state       = state;
    next_cfg         = cfg;
    next_strapped    = 1'b1;
    next_lh          = lh;
    next_lh_reason   = lh_reason;
    next_rm_reason   = rm_reason;
    next_wk_bits     = wk_bits;
    next_wd_cnt      = wd_cnt;
    next_tsd_latched = tsd_latched;
    next_report      = report;
    next_wd_int      = 1'b0;
    next_rst_status  = rst_status;

    // read clears first so that a same-cycle set below wins
    if (read_lh_reason_i || read_rm_reason_i) begin
      next_lh_reason = `LH_REASON_NONE;
      next_rm_reason = `RM_REASON_NONE;
    end
    if (read_wake_i) begin
      next_wk_bits = '0;
    end
    if (read_reset_status_i) begin
      next_rst_status = 1'b0;
    end
    if (spi_response_i) begin
      next_report = 1'b0;
    end

    // strap caught once, on the first edge after reset release
    if (!strapped) begin
      next_cfg = test_pin_low_i ? 3'h0 : {1'b0, config_pins_i} + 3'h1;
    end

    active = (state != ST_POR) && (state != ST_FAILSAFE);

    if (state == ST_FAILSAFE) begin
      if (tsd_latched || thermal_shutdown_i) begin
        next_tsd_latched = thermal_shutdown_i;
        if (!thermal_shutdown_i) begin
          next_state       = ST_RESTART;
        end
      end else if (wake_i) begin
        next_state     = ST_RESTART;
        next_wk_bits   = wake_src_i;
        next_wd_cnt    = '0;
        next_lh        = 1'b1;
        next_lh_reason = `LH_REASON_FS_WAKE;
      end
    end else if (active && thermal_shutdown_i) begin
      next_state       = ST_FAILSAFE;
      next_tsd_latched = 1'b1;
      next_lh_reason   = `LH_REASON_FS_TSD;
    end else if (active && uv_timeout_i && vs_above_lh_thr_i) begin
      next_state     = ST_FAILSAFE;
      next_lh_reason = `LH_REASON_FS_UV;
    end else if (active && reset_clamped_i) begin
      if (cfg == 3'h2 || cfg == 3'h4) begin
        next_state     = ST_FAILSAFE;
        next_lh_reason = `LH_REASON_CLAMP;
      end else begin
        next_state     = ST_RESTART;
        next_lh        = 1'b1;
        next_lh_reason = `LH_REASON_CLAMP;
      end
    end else if (active && reset_ext_low_i) begin
      next_state     = ST_RESTART;
      next_rm_reason = `RM_REASON_EXT;
    end else if (active && uv_reset_i) begin
      next_state     = ST_RESTART;
      next_rm_reason = `RM_REASON_UV;
    end else begin
      unique case (state)
        ST_POR: begin
          if (tif.expired) begin
            next_state = ST_INIT;
          end
        end
        ST_INIT: begin
          if (cmd_normal_i) begin
            next_state = ST_NORMAL;
          end else if (cmd_flash_i) begin
            next_state = ST_FLASH;
          end else if (tif.expired) begin
            next_state     = ST_RESTART;
            next_lh        = 1'b1;
            next_lh_reason = `LH_REASON_INIT_TO;
          end
        end
        ST_NORMAL, ST_STOP: begin
          if (wd_fail_i) begin
            unique case (cfg)
              3'h0: begin
                next_wd_int     = 1'b1;
                next_rst_status = 1'b1;
              end
              3'h1: begin
                next_state     = ST_RESTART;
                next_lh        = 1'b1;
                next_lh_reason = `LH_REASON_WD;
              end
              3'h2: begin
                next_state     = ST_FAILSAFE;
                next_lh_reason = `LH_REASON_FS_WD;
              end
              3'h3: begin
                next_state  = ST_RESTART;
                next_wd_cnt = `WD_CNT_W'(1);
                if (second_fail) begin
                  next_lh        = 1'b1;
                  next_lh_reason = `LH_REASON_WD;
                  next_wd_cnt    = '0;
                end else begin
                  next_rm_reason = `RM_REASON_SW;
                end
              end
              default: begin
                next_wd_cnt = `WD_CNT_W'(1);
                if (second_fail) begin
                  next_state     = ST_FAILSAFE;
                  next_lh_reason = `LH_REASON_FS_WD;
                  next_wd_cnt    = '0;
                end else begin
                  next_state     = ST_RESTART;
                  next_rm_reason = `RM_REASON_SW;
                end
              end
            endcase
          end else if (state == ST_NORMAL) begin
            if (wd_ok_i) begin
              next_wd_cnt = '0;
            end
            if (cmd_flash_i) begin
              next_state = ST_FLASH;
            end else if (cmd_sleep_i) begin
              next_state = ST_SLEEP;
            end else if (cmd_stop_i) begin
              next_state = ST_STOP;
            end
          end else if (cmd_normal_i) begin
            next_state = ST_NORMAL;
          end
        end
        ST_SLEEP: begin
          if (wake_i) begin
            next_state   = ST_RESTART;
            next_wk_bits = wake_src_i;
          end
        end
        ST_FLASH: begin
          if (cmd_restart_i || wd_fail_i) begin
            next_state     = ST_RESTART;
            next_rm_reason = `RM_REASON_SW;
          end
        end
        ST_RESTART: begin
          if (tif.expired) begin
            next_state  = ST_NORMAL;
            next_report = 1'b1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end

    // limp-home software control only where software owns it
    if ((state == ST_NORMAL || state == ST_FLASH) && next_state == state) begin
      if (cmd_lh_on_i) begin
        next_lh = 1'b1;
      end else if (cmd_lh_off_i) begin
        next_lh = 1'b0;
      end
    end
    if (next_state == ST_FAILSAFE) begin
      next_lh = 1'b1;
    end

    next_rst_out_n = !(next_state == ST_RESTART || next_state == ST_POR);
    next_main_en   = (next_state != ST_FAILSAFE) && (next_state != ST_SLEEP);
    next_aux_allow = next_main_en && (next_state != ST_INIT) && (next_state != ST_RESTART)
                     && (next_state != ST_POR);
    next_trx_wk    = (next_state == ST_FAILSAFE) || (next_state == ST_SLEEP);
  end

  // limp-home is carried unchanged through restart, never cleared there
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= ST_POR;
      cfg         <= 3'h0;
      strapped    <= 1'b0;
      lh          <= 1'b0;
      lh_reason   <= `LH_REASON_NONE;
      rm_reason   <= `RM_REASON_NONE;
      wk_bits     <= '0;
      wd_cnt      <= '0;
      tsd_latched <= 1'b0;
      report      <= 1'b0;
      wd_int      <= 1'b0;
      rst_status  <= 1'b0;
      rst_out_n   <= 1'b0;
      main_en     <= 1'b1;
      aux_allow   <= 1'b0;
      trx_wk      <= 1'b0;
    end else begin
      state       <= next_state;
      cfg         <= next_cfg;
      strapped    <= next_strapped;
      lh          <= next_lh;
      lh_reason   <= next_lh_reason;
      rm_reason   <= next_rm_reason;
      wk_bits     <= next_wk_bits;
      wd_cnt      <= next_wd_cnt;
      tsd_latched <= next_tsd_latched;
      report      <= next_report;
      wd_int      <= next_wd_int;
      rst_status  <= next_rst_status;
      rst_out_n   <= next_rst_out_n;
      main_en     <= next_main_en;
      aux_allow   <= next_aux_allow;
      trx_wk      <= next_trx_wk;
    end
  end

  assign mcu_reset_out_n_o       = rst_out_n;
  assign limp_home_output_o      = lh;
  assign main_regulator_en_o     = main_en;
  assign aux_regulators_allow_o  = aux_allow;
  assign trx_wake_capable_o      = trx_wk;
  assign limp_home_reason_bits_o = lh_reason;
  assign restart_reason_bits_o   = rm_reason;
  assign wake_source_bits_o      = wk_bits;
  assign reason_report_pending_o = report;
  assign wd_fail_int_o           = wd_int;
  assign reset_status_bit_o      = rst_status;
  assign mode_o                  = state;
  assign config_o                = cfg;
endmodule
`default_nettype wire

// ===== verilog/sbc_seq_defs.svh
// constants of the restart and fail-safe mode sequencer
`ifndef SBC_SEQ_DEFS_SVH
`define SBC_SEQ_DEFS_SVH

`define CLK_MHZ              100
`define INIT_TIMEOUT_MS      256
`define INIT_TIMEOUT_CYC     (`INIT_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define RST_DELAY_SHORT_US   2000
`define RST_DELAY_LONG_US    10000
`define RST_DELAY_SHORT_CYC  (`RST_DELAY_SHORT_US * `CLK_MHZ)
`define RST_DELAY_LONG_CYC   (`RST_DELAY_LONG_US * `CLK_MHZ)
`define TIMER_W              25

`define LH_REASON_NONE       3'h0
`define LH_REASON_INIT_TO    3'h1
`define LH_REASON_CLAMP      3'h2
`define LH_REASON_WD         3'h3
`define LH_REASON_FS_WAKE    3'h4
`define LH_REASON_FS_UV      3'h5
`define LH_REASON_FS_TSD     3'h6
`define LH_REASON_FS_WD      3'h7

`define RM_REASON_NONE       2'h0
`define RM_REASON_EXT        2'h1
`define RM_REASON_UV         2'h2
`define RM_REASON_SW         2'h3

`define WD_CNT_W             2
`define WAKE_W               4

`endif

// ===== verilog/sbc_seq_pkg.sv
// types of the restart and fail-safe mode sequencer
package sbc_seq_pkg;
  typedef enum logic [2:0] {
    ST_POR      = 3'h0,
    ST_INIT     = 3'h1,
    ST_NORMAL   = 3'h2,
    ST_STOP     = 3'h3,
    ST_SLEEP    = 3'h4,
    ST_FLASH    = 3'h5,
    ST_RESTART  = 3'h6,
    ST_FAILSAFE = 3'h7
  } sbc_mode_t;

  typedef logic [2:0] config_sel_t;
endpackage

// ===== verilog/delay_timer_if.sv
// load and expiry handshake between sequencer and its delay timer
`timescale 1ns/1ps
`default_nettype none
interface delay_timer_if #(parameter int W = 25);
  logic         load;
  logic [W-1:0] value;
  logic         expired;
  modport ctrl (output load, output value, input expired);
  modport tmr  (input load, input value, output expired);
endinterface
`default_nettype wire

// ===== verilog/delay_timer.sv
// down counter that pulses expired when a loaded delay has run out
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int W = 25
) (
  input  wire logic   clock_i,
  input  wire logic   rst_n_i,
  delay_timer_if.tmr  tif
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         expired;
  logic         next_expired;

  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (tif.load) begin
      next_count = tif.value;
    end else if (count != '0) begin
      next_count   = count - W'(1);
      next_expired = (count == W'(1));
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign tif.expired = expired;
endmodule
`default_nettype wire

// ===== sim/sbc_restart_failsafe_modes_props.sv
// port-level assertions of the restart and fail-safe mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sbc_seq_defs.svh"
module sbc_restart_failsafe_modes_props
  import sbc_seq_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       reset_delay_sel_i,
  input wire logic       wd_fail_i,
  input wire logic       reset_ext_low_i,
  input wire logic       thermal_shutdown_i,
  input wire logic       mcu_reset_out_n_o,
  input wire logic       limp_home_output_o,
  input wire logic       main_regulator_en_o,
  input wire logic       aux_regulators_allow_o,
  input wire logic       trx_wake_capable_o,
  input wire logic [1:0] restart_reason_bits_o,
  input wire logic       reason_report_pending_o,
  input wire logic       wd_fail_int_o,
  input wire logic       reset_status_bit_o,
  input wire logic [2:0] mode_o,
  input wire logic [2:0] config_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_restart_entry;
    $rose(mode_o == ST_RESTART);
  endsequence
  sequence s_restart_exit;
    $past(mode_o) == ST_RESTART && !(mode_o inside {ST_RESTART, ST_FAILSAFE});
  endsequence
  sequence s_dev_wd;
    config_o == 3'h0 && mode_o == ST_NORMAL && wd_fail_i;
  endsequence
  property p_reset_low; mode_o == ST_RESTART |-> !mcu_reset_out_n_o; endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset output high in restart");
  property p_restart_exit; s_restart_exit |-> mode_o == ST_NORMAL && mcu_reset_out_n_o; endproperty
  a_restart_exit: assert property (p_restart_exit)
    else $error("restart left wrongly");
  property p_report; s_restart_exit |-> reason_report_pending_o; endproperty
  a_report: assert property (p_report)
    else $error("no reason report pending");
  property p_short_delay;
    s_restart_entry ##0 !reset_delay_sel_i |-> (mode_o == ST_RESTART)[*5] ##[1:3] mode_o == ST_NORMAL;
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("short restart delay wrong");
  property p_lh_kept;
    (mode_o == ST_RESTART || $past(mode_o) == ST_RESTART) && $past(limp_home_output_o)
      |-> limp_home_output_o;
  endproperty
  a_lh_kept: assert property (p_lh_kept)
    else $error("limp home dropped around restart");
  property p_failsafe;
    mode_o == ST_FAILSAFE |-> !main_regulator_en_o && !aux_regulators_allow_o
      && trx_wake_capable_o && limp_home_output_o;
  endproperty
  a_failsafe: assert property (p_failsafe)
    else $error("fail-safe outputs wrong");
  property p_cfg2_wd; config_o == 3'h2 && mode_o == ST_NORMAL && wd_fail_i |=> mode_o == ST_FAILSAFE; endproperty
  a_cfg2_wd: assert property (p_cfg2_wd)
    else $error("config 2 watchdog failure not fail-safe");
  property p_hot; mode_o == ST_FAILSAFE && thermal_shutdown_i |=> mode_o == ST_FAILSAFE; endproperty
  a_hot: assert property (p_hot)
    else $error("fail-safe left while hot");
  property p_ext_reset;
    reset_ext_low_i && !thermal_shutdown_i && mode_o == ST_NORMAL |=> mode_o == ST_RESTART
      && restart_reason_bits_o == `RM_REASON_EXT && main_regulator_en_o;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset not handled");
  property p_dev_wd; s_dev_wd |=> mode_o == ST_NORMAL && mcu_reset_out_n_o && main_regulator_en_o; endproperty
  a_dev_wd: assert property (p_dev_wd)
    else $error("development mode reacted to watchdog");
  property p_dev_int; s_dev_wd |=> wd_fail_int_o && reset_status_bit_o ##1 !wd_fail_int_o; endproperty
  a_dev_int: assert property (p_dev_int)
    else $error("development watchdog flag wrong");
endmodule
bind sbc_restart_failsafe_modes sbc_restart_failsafe_modes_props i_sbc_restart_failsafe_modes_props (
  .clock_i, .rst_n_i, .reset_delay_sel_i, .wd_fail_i, .reset_ext_low_i, .thermal_shutdown_i,
  .mcu_reset_out_n_o, .limp_home_output_o, .main_regulator_en_o, .aux_regulators_allow_o,
  .trx_wake_capable_o, .restart_reason_bits_o, .reason_report_pending_o, .wd_fail_int_o,
  .reset_status_bit_o, .mode_o, .config_o);
`default_nettype wire

// ===== sim/mcu_model.sv
// microcontroller stand-in: leaves init by command and reads the first response
`timescale 1ns/1ps
`default_nettype none
module mcu_model
  import sbc_seq_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       mcu_reset_n_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       en_i,
  input  wire logic [3:0] dly_i,
  output var  logic       cmd_normal_o,
  output var  logic       spi_response_o
);
  initial begin
    cmd_normal_o = 1'b0;
    spi_response_o = 1'b0;
    forever begin
      @(posedge mcu_reset_n_i);
      if (en_i) begin
        repeat (dly_i) @(posedge clock_i);
        #1;
        if (mode_i == ST_INIT) begin
          cmd_normal_o = 1'b1;
          @(posedge clock_i);
          #1;
          cmd_normal_o = 1'b0;
        end
        repeat (dly_i) @(posedge clock_i);
        #1;
        spi_response_o = 1'b1;
        @(posedge clock_i);
        #1;
        spi_response_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/sbc_restart_failsafe_modes_test.sv
// self-checking bench of the restart and fail-safe mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sbc_seq_defs.svh"
module sbc_restart_failsafe_modes_test;
  import sbc_seq_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n = 1'b0;
  logic        test_low, dly_sel, clamp, uv_to, hot, mcu_en, vs_ok, cmd_normal, spi_resp;
  logic [1:0]  pins, rm_rsn;
  logic [3:0]  src, wk_bits;
  // 0 wd fail 1 wake 2 ext reset 3 uv reset 4 flash 5 restart 6 sleep 7 read rm
  // 8 read status 9 wd ok 10 stop 11 lh on 12 lh off 13 read lh 14 read wake
  logic [14:0] ev;
  logic        rst_out_n, lh, main_en, aux, trx, pend, wd_int, rst_stat;
  logic [2:0]  lh_rsn, mode, cfg;
  int          fails = 0;
  int          checks = 0;
  always #5 clock_i = ~clock_i;
  sbc_restart_failsafe_modes #(.INIT_TIMEOUT(25'h14), .RST_DELAY_SHORT(25'h5),
    .RST_DELAY_LONG(25'hA)) i_sbc_restart_failsafe_modes (
    .clock_i(clock_i), .rst_n_i(rst_n), .test_pin_low_i(test_low), .config_pins_i(pins),
    .reset_delay_sel_i(dly_sel), .cmd_normal_i(cmd_normal), .cmd_flash_i(ev[4]),
    .cmd_sleep_i(ev[6]), .cmd_stop_i(ev[10]), .cmd_restart_i(ev[5]), .cmd_lh_on_i(ev[11]),
    .cmd_lh_off_i(ev[12]), .wd_fail_i(ev[0]), .wd_ok_i(ev[9]), .reset_ext_low_i(ev[2]),
    .reset_clamped_i(clamp), .uv_reset_i(ev[3]), .uv_timeout_i(uv_to),
    .vs_above_lh_thr_i(vs_ok), .thermal_shutdown_i(hot), .wake_i(ev[1]), .wake_src_i(src),
    .spi_response_i(spi_resp), .read_lh_reason_i(ev[13]), .read_rm_reason_i(ev[7]),
    .read_wake_i(ev[14]), .read_reset_status_i(ev[8]), .mcu_reset_out_n_o(rst_out_n),
    .limp_home_output_o(lh), .main_regulator_en_o(main_en), .aux_regulators_allow_o(aux),
    .trx_wake_capable_o(trx), .limp_home_reason_bits_o(lh_rsn), .restart_reason_bits_o(rm_rsn),
    .wake_source_bits_o(wk_bits), .reason_report_pending_o(pend), .wd_fail_int_o(wd_int),
    .reset_status_bit_o(rst_stat), .mode_o(mode), .config_o(cfg));
  mcu_model i_mcu_model (.clock_i(clock_i), .mcu_reset_n_i(rst_out_n), .mode_i(mode),
    .en_i(mcu_en), .dly_i(4'h2), .cmd_normal_o(cmd_normal), .spi_response_o(spi_resp));
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    step();
    ev[k] = 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st();
    return {lh, rst_out_n, main_en, rm_rsn, lh_rsn};
  endfunction
  task automatic wait_mode(input logic [2:0] m);
    for (int n = 0; n < 60 && mode !== m; n++) step();
    chk(mode, m);
  endtask
  task automatic boot(input logic tl, input logic [1:0] p);
    rst_n = 1'b0;
    test_low = tl;
    pins = p;
    step(2);
    chk({lh, trx}, 8'h0);
    rst_n = 1'b1;
    wait_mode(ST_NORMAL);
    chk(cfg, tl ? 8'h0 : 8'(p) + 8'h1);
  endtask
  // restart length in cycles, then the return to normal
  task automatic restart_len(input int d);
    int n;
    n = 0;
    while (mode === ST_RESTART && n < 40) begin
      step();
      n++;
    end
    chk(8'(n >= d && n <= d + 2), 8'h1);
    chk({rst_out_n, pend, mode}, {2'b11, ST_NORMAL});
  endtask
  task automatic t_init_timeout();
    mcu_en = 1'b0;
    step(2);
    rst_n = 1'b1;
    wait_mode(ST_INIT);
    wait_mode(ST_RESTART);
    mcu_en = 1'b1;
    chk(st(), {3'b101, `RM_REASON_NONE, `LH_REASON_INIT_TO});
    restart_len(5);
    step(8);
    chk(pend, 1'b0);
    $display("init timeout test done");
  endtask
  task automatic t_cfg1();
    boot(1'b0, 2'h0);
    dly_sel = 1'b1;
    pulse(0);
    chk(st(), {3'b101, `RM_REASON_NONE, `LH_REASON_WD});
    restart_len(10);
    chk({lh, lh_rsn}, {1'b1, `LH_REASON_WD});
    pulse(7);
    chk({rm_rsn, lh_rsn}, 8'h0);
    pulse(12);
    chk(lh, 1'b0);
    pulse(11);
    pulse(10);
    chk({mode, lh}, {ST_STOP, 1'b1});
    dly_sel = 1'b0;
    clamp = 1'b1;
    step();
    clamp = 1'b0;
    chk({mode, lh, lh_rsn}, {ST_RESTART, 1'b1, `LH_REASON_CLAMP});
    $display("config 1 test done");
  endtask
  task automatic t_cfg3();
    boot(1'b0, 2'h2);
    pulse(0);
    chk(st(), {3'b001, `RM_REASON_SW, `LH_REASON_NONE});
    restart_len(5);
    pulse(9);
    pulse(0);
    chk(st(), {3'b001, `RM_REASON_SW, `LH_REASON_NONE});
    restart_len(5);
    pulse(0);
    chk(st(), {3'b101, `RM_REASON_SW, `LH_REASON_WD});
    $display("config 3 test done");
  endtask
  task automatic t_cfg4();
    boot(1'b0, 2'h3);
    pulse(0);
    chk(st(), {3'b001, `RM_REASON_SW, `LH_REASON_NONE});
    restart_len(5);
    pulse(0);
    chk({mode, lh_rsn}, {ST_FAILSAFE, `LH_REASON_FS_WD});
    chk({lh, main_en, aux, trx}, 8'h9);
    src = 4'h9;
    pulse(1);
    chk({mode, lh, lh_rsn}, {ST_RESTART, 1'b1, `LH_REASON_FS_WAKE});
    chk(wk_bits, 4'h9);
    restart_len(5);
    pulse(13);
    pulse(14);
    chk({wk_bits, lh_rsn}, 8'h0);
    pulse(0);
    chk(mode, ST_RESTART);
    $display("config 4 test done");
  endtask
  task automatic t_cfg2();
    boot(1'b0, 2'h1);
    pulse(0);
    chk(mode, ST_FAILSAFE);
    pulse(1);
    restart_len(5);
    clamp = 1'b1;
    step();
    clamp = 1'b0;
    chk(mode, ST_FAILSAFE);
    pulse(1);
    restart_len(5);
    hot = 1'b1;
    step();
    chk({mode, lh_rsn}, {ST_FAILSAFE, `LH_REASON_FS_TSD});
    pulse(1);
    chk(mode, ST_FAILSAFE);
    hot = 1'b0;
    wait_mode(ST_RESTART);
    $display("config 2 test done");
  endtask
  task automatic t_cfg0();
    boot(1'b1, 2'h2);
    pulse(0);
    chk({mode, wd_int, rst_stat, rst_out_n}, {ST_NORMAL, 3'b111});
    step();
    chk(wd_int, 1'b0);
    pulse(8);
    chk(rst_stat, 1'b0);
    pulse(2);
    chk({mode, rm_rsn, main_en}, {ST_RESTART, `RM_REASON_EXT, 1'b1});
    restart_len(5);
    pulse(3);
    chk({mode, rm_rsn, main_en}, {ST_RESTART, `RM_REASON_UV, 1'b1});
    restart_len(5);
    pulse(4);
    wait_mode(ST_FLASH);
    pulse(5);
    chk({mode, rm_rsn}, {ST_RESTART, `RM_REASON_SW});
    restart_len(5);
    pulse(6);
    chk(mode, ST_SLEEP);
    src = 4'h5;
    pulse(1);
    chk({mode, wk_bits, wd_int}, {ST_RESTART, 4'h5, 1'b0});
    restart_len(5);
    {uv_to, vs_ok} = 2'b10;
    step();
    chk(mode, ST_NORMAL);
    vs_ok = 1'b1;
    step();
    uv_to = 1'b0;
    chk({mode, lh_rsn}, {ST_FAILSAFE, `LH_REASON_FS_UV});
    $display("config 0 test done");
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {test_low, dly_sel, clamp, uv_to, hot, pins, src, ev} = '0;
    {mcu_en, vs_ok} = 2'b11;
    t_init_timeout();
    t_cfg1();
    t_cfg3();
    t_cfg4();
    t_cfg2();
    t_cfg0();
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
